// ---- design/sensor_consts.svh ----
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH

// Configuration word addresses on the parallel configuration port.
`define CFG_ADDR_START_X   4'h0
`define CFG_ADDR_START_Y   4'h1
`define CFG_ADDR_WIDTH     4'h2
`define CFG_ADDR_OVERHEAD_GRANULARITY      4'h3
`define CFG_ADDR_MODE      4'h4
`define CFG_WORDS          3'h5

// Power-on defaults of the configuration settings.
`define DEF_START_X        12'h000
`define DEF_START_Y        12'h000
`define DEF_WIDTH          12'h280
`define DEF_OVERHEAD_GRANULARITY           2'h0
`define DEF_MASTER         1'b1

// Array geometry and overhead length in core ticks: 12*(overhead_granularity+1)+1.
`define ARRAY_ROWS         12'h1e0
`define OVH_STEP           6'h0c
`define OVH_EXTRA          6'h01

// Timing figures and their cycle counts at the clock rate.
`define CLK_PERIOD_NS      10
`define SEQ_RST_MIN_NS     50
`define SUPPLY_RST_MIN_NS  500
`define PIX_RESET_MIN_NS   2000
`define SEQ_RST_MIN_CYC    ((`SEQ_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SUPPLY_RST_CYC     ((`SUPPLY_RST_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PIX_RESET_CYC      ((`PIX_RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CORE_START_CYC     8
`define FOT_HOLD_CYC       8

`endif

// ---- design/sensor_pkg.sv ----
package sensor_pkg;

    typedef enum logic [1:0] {DS_WAIT, DS_FOT, DS_ROT, DS_READ} dev_state_e;
    typedef enum logic [1:0] {CS_CFG, CS_HOLD, CS_FOT, CS_FRAME} ctl_state_e;

    typedef struct packed {
        logic [11:0] start_x;
        logic [11:0] start_y;
        logic [11:0] width;
        logic [1:0]  overhead_granularity;
        logic        master;
        logic        running;
        logic [1:0]  div;
        dev_state_e  st;
        logic [5:0]  cnt;
        logic [11:0] row;
        logic [11:0] rows_done;
        logic [11:0] col;
        logic        line_valid;
        logic        frame_valid;
        logic        strobe;
        logic [9:0]  data;
        logic [2:0]  int_o;
        logic [2:0]  int_oe;
        logic        fot_req;
        logic        all_low_d;
        logic        pixel_reset;
        logic        integrating;
        logic        lower_reset;
    } dev_s;

    typedef struct packed {
        ctl_state_e       st;
        logic [15:0]      cnt;
        logic [2:0]       cfg_idx;
        logic             cfg_wr;
        logic [3:0]       cfg_addr;
        logic [11:0]      cfg_data;
        logic             seq_rst_n;
        logic [2:0]       int_o;
        logic [11:0]      falls;
        logic [11:0]      rel_fall;
        logic             lv_d;
        logic [1:0][9:0]  buf_data;
        logic [1:0]       buf_v;
        logic             pix_ready;
        logic             busy;
    } ctl_s;

endpackage : sensor_pkg

// ---- design/sensor_link_if.sv ----
`timescale 1ns/1ns
interface sensor_link_if;
    // Sequencer reset and configuration port, driven by the controller.
    logic        seq_rst_n;
    logic        cfg_wr;
    logic [3:0]  cfg_addr;
    logic [11:0] cfg_data;
    // Integration control pins, two-way, active low in slave mode.
    logic [2:0]  dev_int_o;
    logic [2:0]  dev_int_oe;
    logic [2:0]  ctl_int_o;
    logic [2:0]  ctl_int_oe;
    logic [2:0]  int_time;
    // Readout stream.
    logic        line_valid;
    logic        frame_valid;
    logic [9:0]  pix_data;
    logic        pix_strobe;
    logic        pix_ready;

    // Undriven pins float high, as with a pull-up.
    for (genvar i = 0; i < 3; i++) begin : g_pin
        assign int_time[i] = dev_int_oe[i] ? dev_int_o[i] :
                             (ctl_int_oe[i] ? ctl_int_o[i] : 1'b1);
    end

    modport dev (
        input  seq_rst_n, cfg_wr, cfg_addr, cfg_data, int_time, pix_ready,
        output dev_int_o, dev_int_oe, line_valid, frame_valid, pix_data, pix_strobe
    );
    modport ctl (
        input  int_time, line_valid, frame_valid, pix_data, pix_strobe,
        output seq_rst_n, cfg_wr, cfg_addr, cfg_data, ctl_int_o, ctl_int_oe, pix_ready
    );
endinterface : sensor_link_if

// ---- design/sensor_readout_dev.sv ----
`timescale 1ns/1ns
// Overview of operation
// R1: Window starts at start row/column; width from setting.
// R2: Slave mode reads rows until frame overhead starts.
// R3: Rows beyond array still read normally.
// R4: Controller ignores row pulses outside its window.
// R5: Overhead lengths follow the granularity setting.
// R6: Long readout: release main control at difference.
// R7: All three controls low start frame overhead.
// R8: Short readout: main control reset at least 2us.
// R9: Power-on clear restores configuration defaults.
// R10: Controller holds sequencer reset during initial configuration.
// R11: Sequencer reset held 500ns after supplies stable.
// R12: Reset release starts divider; tick on second edge.
// R13: Some settings written once core clock runs; the controller writes all five settings under sequencer reset.
// R14: Sequencer reset low returns sequencer to start.
// R15: Sequencer reset keeps configuration; rewrites allowed then.
// R16: Integration pins: outputs in master, inputs in slave.
// R17: Row-valid high exactly while row data present.
// R18: Frame-active marks the frame being read out.
// R19: Serial configuration clock at most 20 MHz.
// R20: Core clock is input clock divided by four.
// R21: Slave mode: three controls are active-low inputs.
// R22: Main low, others high resets pixels; release integrates.
// R23: Second or third control alone gives lower reset.
// R24: Controller counts row pulses from frame start.
`include "sensor_consts.svh"

module sensor_readout_dev
    import sensor_pkg::*;
(
    // Clock and power-on reset
    input  wire logic   clock,
    input  wire logic   nrst,
    // Link to the camera controller
    sensor_link_if.dev  link,
    // Pixel state seen from the integration controls
    output logic        pixel_reset,
    output logic        integrating,
    output logic        lower_reset
);

    dev_s r_reg;
    dev_s r_next;

    logic       tick;
    logic       all_low;
    logic [5:0] ovh;
    logic       last_col;

    always_comb begin
        r_next = r_reg;
        // R20: one core tick every fourth clock edge
        tick = r_reg.running && (r_reg.div == 2'h0);
        // R21: active-low pins, all three low is the frame overhead request
        all_low = !r_reg.master && (link.int_time == 3'h0);
        // R5: overhead length from granularity
        ovh = 6'((`OVH_STEP * (6'(r_reg.overhead_granularity) + 6'h01)) + `OVH_EXTRA - 6'h01);
        last_col = (r_reg.col == 12'(r_reg.start_x + r_reg.width - 12'h001));
        r_next.strobe = 1'b0;
        r_next.all_low_d = all_low;

        // R15: the configuration port answers whether or not the sequencer runs
        if (link.cfg_wr) begin
            unique case (link.cfg_addr)
                `CFG_ADDR_START_X: r_next.start_x = link.cfg_data;
                `CFG_ADDR_START_Y: r_next.start_y = link.cfg_data;
                `CFG_ADDR_WIDTH:   r_next.width = link.cfg_data;
                `CFG_ADDR_OVERHEAD_GRANULARITY:    r_next.overhead_granularity = link.cfg_data[1:0];
                `CFG_ADDR_MODE:    r_next.master = link.cfg_data[0];
                default:           r_next.start_x = r_reg.start_x;
            endcase
        end

        // R22: pixel reset while main is low and the others high
        r_next.pixel_reset = !r_reg.master && (link.int_time == 3'b110);
        if (r_reg.pixel_reset && link.int_time[0]) begin
            r_next.integrating = 1'b1;
        end
        // R23: a lone second or third control gives a lower reset
        r_next.lower_reset = r_reg.integrating && link.int_time[0] &&
                             (!link.int_time[1] || !link.int_time[2]);

        // R7: a new all-low condition requests the frame overhead; set wins
        if (all_low && !r_reg.all_low_d) begin
            r_next.fot_req = 1'b1;
        end

        if (r_reg.running) begin
            r_next.div = r_reg.div + 2'h1;
        end else begin
            r_next.running = 1'b1;
        end

        if (tick) begin
            unique case (r_reg.st)
                DS_WAIT: begin
                    if (r_reg.fot_req) begin
                        r_next.st = DS_FOT;
                        r_next.cnt = ovh;
                        r_next.fot_req = all_low && !r_reg.all_low_d;
                    end
                end
                DS_FOT: begin
                    if (r_reg.cnt == 6'h00) begin
                        // R1: rows start at the start row
                        r_next.st = DS_ROT;
                        r_next.cnt = ovh;
                        r_next.row = r_reg.start_y;
                        r_next.rows_done = 12'h000;
                        // R18: frame-active from the first row overhead
                        r_next.frame_valid = 1'b1;
                        r_next.integrating = 1'b0;
                    end else begin
                        r_next.cnt = r_reg.cnt - 6'h01;
                    end
                end
                DS_ROT: begin
                    r_next.line_valid = 1'b0;
                    if (r_reg.cnt == 6'h00) begin
                        r_next.st = DS_READ;
                        // R1: each row starts at the start column
                        r_next.col = r_reg.start_x;
                    end else begin
                        r_next.cnt = r_reg.cnt - 6'h01;
                    end
                end
                DS_READ: begin
                    // A stalled receiver holds the column pointer, so no word is lost.
                    if (link.pix_ready) begin
                        // R17: row-valid rises with the first word of the row
                        r_next.line_valid = 1'b1;
                        r_next.strobe = 1'b1;
                        r_next.data = r_reg.col[9:0] ^ r_reg.row[9:0];
                        r_next.col = r_reg.col + 12'h001;
                        if (last_col) begin
                            // R2: no vertical size, the next row follows
                            // R3: rows past the array run the same way
                            r_next.st = DS_ROT;
                            r_next.cnt = ovh;
                            r_next.row = r_reg.row + 12'h001;
                            r_next.rows_done = r_reg.rows_done + 12'h001;
                            if (r_reg.master && (r_reg.rows_done == `ARRAY_ROWS - 12'h001)) begin
                                r_next.fot_req = 1'b1;
                            end
                        end
                    end
                end
            endcase

            // R7: the overhead request cuts the readout short at any row
            if (r_reg.fot_req && (r_reg.st == DS_ROT || r_reg.st == DS_READ)) begin
                r_next.st = DS_FOT;
                r_next.cnt = ovh;
                r_next.line_valid = 1'b0;
                // R18: frame-active falls when the frame overhead starts
                r_next.frame_valid = 1'b0;
                r_next.fot_req = all_low && !r_reg.all_low_d;
            end
        end

        // R16: pins drive out in master mode only
        r_next.int_oe = {3{r_reg.master}};
        r_next.int_o = {3{r_reg.master && r_reg.st != DS_FOT}};

        // R14: sequencer reset returns the sequencer to its start state
        // R12: divider held until release; first tick at the second edge
        if (!link.seq_rst_n) begin
            r_next.running = 1'b0;
            r_next.div = 2'h0;
            r_next.st = DS_WAIT;
            r_next.cnt = 6'h00;
            r_next.row = 12'h000;
            r_next.rows_done = 12'h000;
            r_next.col = 12'h000;
            r_next.line_valid = 1'b0;
            r_next.frame_valid = 1'b0;
            r_next.strobe = 1'b0;
            r_next.fot_req = 1'b0;
            r_next.integrating = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            // R9: power-on clear restores configuration defaults
            r_reg <= '{start_x: `DEF_START_X, start_y: `DEF_START_Y, width: `DEF_WIDTH,
                       overhead_granularity: `DEF_OVERHEAD_GRANULARITY, master: `DEF_MASTER, st: DS_WAIT, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.dev_int_o = r_reg.int_o;
    assign link.dev_int_oe = r_reg.int_oe;
    assign link.line_valid = r_reg.line_valid;
    assign link.frame_valid = r_reg.frame_valid;
    assign link.pix_data = r_reg.data;
    assign link.pix_strobe = r_reg.strobe;
    assign pixel_reset = r_reg.pixel_reset;
    assign integrating = r_reg.integrating;
    assign lower_reset = r_reg.lower_reset;

endmodule : sensor_readout_dev

// ---- design/sensor_camera_ctl.sv ----
`timescale 1ns/1ns
`include "sensor_consts.svh"

module sensor_camera_ctl
    import sensor_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         nrst,
    // Link to the sensor
    sensor_link_if.ctl        link,
    // Readout settings
    input  wire logic [11:0]  start_x,
    input  wire logic [11:0]  start_y,
    input  wire logic [11:0]  width,
    input  wire logic [1:0]   overhead_granularity,
    input  wire logic [11:0]  win_rows,
    input  wire logic [11:0]  int_rows,
    // Captured pixel stream
    output logic [9:0]        out_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    // Status
    output logic              busy
);

    ctl_s r_reg;
    ctl_s r_next;

    logic        fell;
    logic        push;
    logic        pop;
    logic [11:0] rel_at;
    logic [11:0] fot_at;
    logic [11:0] cfg_word;
    logic [1:0]  v_mid;

    always_comb begin
        r_next = r_reg;
        r_next.cfg_wr = 1'b0;
        r_next.lv_d = link.line_valid;
        fell = r_reg.lv_d && !link.line_valid;
        // R6: long readout releases at the row difference, short at the first row
        rel_at = (win_rows > int_rows) ? 12'(win_rows - int_rows) : 12'h001;
        fot_at = 12'(r_reg.rel_fall + int_rows);
        if (fot_at < win_rows) begin
            fot_at = win_rows;
        end
        unique case (r_reg.cfg_idx)
            3'h0:    cfg_word = start_x;
            3'h1:    cfg_word = start_y;
            3'h2:    cfg_word = width;
            3'h3:    cfg_word = {10'h000, overhead_granularity};
            default: cfg_word = 12'h000;
        endcase
        if (r_reg.cnt != 16'hffff) begin
            r_next.cnt = r_reg.cnt + 16'h0001;
        end

        unique case (r_reg.st)
            CS_CFG: begin
                // R10: sequencer reset low while the settings go in
                r_next.seq_rst_n = 1'b0;
                if (r_reg.cnt[0]) begin
                    r_next.cfg_wr = 1'b1;
                    r_next.cfg_addr = 4'(r_reg.cfg_idx);
                    r_next.cfg_data = cfg_word;
                    r_next.cfg_idx = r_reg.cfg_idx + 3'h1;
                    if (r_reg.cfg_idx == `CFG_WORDS - 3'h1) begin
                        r_next.st = CS_HOLD;
                        r_next.cnt = 16'h0000;
                    end
                end
            end
            CS_HOLD: begin
                // R11: hold the reset past the supply settling time
                if (r_reg.cnt == 16'(`SUPPLY_RST_CYC)) begin
                    r_next.seq_rst_n = 1'b1;
                end
                // R13: wait for the core clock before the first frame
                if (r_reg.cnt == 16'(`SUPPLY_RST_CYC + `CORE_START_CYC)) begin
                    r_next.st = CS_FOT;
                    r_next.cnt = 16'h0000;
                    r_next.busy = 1'b1;
                end
            end
            CS_FOT: begin
                // R7: all three controls low together
                r_next.int_o = 3'b000;
                if (r_reg.cnt == 16'(`FOT_HOLD_CYC)) begin
                    // R22: main low with others high resets the pixels
                    r_next.int_o = 3'b110;
                    r_next.st = CS_FRAME;
                    r_next.cnt = 16'h0000;
                    r_next.falls = 12'h000;
                    r_next.rel_fall = 12'hfff;
                end
            end
            CS_FRAME: begin
                // R24: count row pulses from frame start
                if (fell) begin
                    r_next.falls = r_reg.falls + 12'h001;
                end
                // R8: release after 2us and once rel_at row falling edges are counted
                if (!r_reg.int_o[0] && r_reg.cnt >= 16'(`PIX_RESET_CYC) &&
                    r_reg.falls >= rel_at) begin
                    r_next.int_o = 3'b111;
                    r_next.rel_fall = r_reg.falls;
                end
                // R7: frame overhead once both the last wanted row and int_rows rows after the release are past
                if (r_reg.int_o[0] && r_reg.falls >= fot_at) begin
                    r_next.st = CS_FOT;
                    r_next.cnt = 16'h0000;
                end
            end
        endcase

        // R4: keep only rows inside the window and inside the array
        push = link.pix_strobe && link.frame_valid && (r_reg.falls < win_rows) &&
               (12'(r_reg.falls + start_y) < `ARRAY_ROWS) && r_reg.st == CS_FRAME;
        pop = r_reg.buf_v[0] && out_ready;
        v_mid = r_reg.buf_v;
        if (pop) begin
            r_next.buf_data[0] = r_reg.buf_data[1];
            v_mid = {1'b0, r_reg.buf_v[1]};
        end
        if (push) begin
            if (v_mid[0]) begin
                r_next.buf_data[1] = link.pix_data;
            end else begin
                r_next.buf_data[0] = link.pix_data;
            end
            v_mid = {v_mid[0], 1'b1};
        end
        r_next.buf_v = v_mid;
        r_next.pix_ready = !v_mid[1];
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            r_reg <= '{st: CS_CFG, int_o: 3'b111, pix_ready: 1'b1, default: '0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign link.seq_rst_n = r_reg.seq_rst_n;
    assign link.cfg_wr = r_reg.cfg_wr;
    assign link.cfg_addr = r_reg.cfg_addr;
    assign link.cfg_data = r_reg.cfg_data;
    // R21: the controller always drives the pins; slave mode is written at start.
    assign link.ctl_int_o = r_reg.int_o;
    assign link.ctl_int_oe = 3'b111;
    assign link.pix_ready = r_reg.pix_ready;
    assign out_data = r_reg.buf_data[0];
    assign out_valid = r_reg.buf_v[0];
    assign busy = r_reg.busy;

endmodule : sensor_camera_ctl

// ---- tb/sensor_link_checker.sv ----
`timescale 1ns/1ns
`include "sensor_consts.svh"
module sensor_link_checker (
    // Clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // Controller side
    input wire logic        seq_rst_n,
    input wire logic        cfg_wr,
    input wire logic [3:0]  cfg_addr,
    input wire logic [11:0] cfg_data,
    // Device side
    input wire logic [2:0]  dev_int_oe,
    input wire logic [2:0]  int_time,
    input wire logic        line_valid,
    input wire logic        frame_valid,
    input wire logic        pix_strobe
);
    logic [11:0] width_reg;
    logic [11:0] words_reg;
    logic [8:0]  low_reg;
    logic [2:0]  prev_reg;
    logic [1:0]  overhead_granularity_reg;
    logic [1:0]  phase_reg;
    logic        master_reg;
    logic        fot_reg;
    logic        req_reg;
    logic        req;
    int          fot_cyc;

    // The request is the edge into all three controls low, so a held low level counts once.
    assign req     = !master_reg && int_time == 3'h0 && prev_reg != 3'h0;
    assign fot_cyc = 3'h4 * (`OVH_STEP * (overhead_granularity_reg + 2'h1) + `OVH_EXTRA);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            width_reg  <= `DEF_WIDTH;
            overhead_granularity_reg   <= `DEF_OVERHEAD_GRANULARITY;
            master_reg <= `DEF_MASTER;
            prev_reg   <= 3'h7;
            words_reg  <= 12'h0;
            low_reg    <= 9'h0;
            phase_reg  <= 2'h0;
            fot_reg    <= 1'b0;
            req_reg    <= 1'b0;
        end else begin
            if (cfg_wr && cfg_addr == `CFG_ADDR_WIDTH) begin
                width_reg <= cfg_data;
            end
            if (cfg_wr && cfg_addr == `CFG_ADDR_OVERHEAD_GRANULARITY) begin
                overhead_granularity_reg <= cfg_data[1:0];
            end
            if (cfg_wr && cfg_addr == `CFG_ADDR_MODE) begin
                master_reg <= cfg_data[0];
            end
            prev_reg  <= int_time;
            words_reg <= line_valid ? words_reg + 12'(pix_strobe) : 12'h0;
            low_reg   <= frame_valid ? 9'h0 : low_reg + 9'h1;
            phase_reg <= seq_rst_n ? phase_reg + 2'h1 : 2'h0;
            fot_reg   <= seq_rst_n && (fot_reg ? !frame_valid : $fell(frame_valid));
            req_reg   <= req || (req_reg && frame_valid);
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    cfg_order_a: assert property (cfg_wr |-> !seq_rst_n)
        else $error("Configuration written after sequencer release.");
    seq_idle_a: assert property (!seq_rst_n ##1 !seq_rst_n |-> !frame_valid && !line_valid)
        else $error("Readout active under sequencer reset.");
    tick_phase_a: assert property (pix_strobe |-> phase_reg == 2'h2)
        else $error("Pixel word off the core clock phase.");
    fot_drop_a: assert property (req |-> ##[1:6] !frame_valid)
        else $error("Frame overhead not started after request.");
    fot_len_a: assert property ($rose(frame_valid) && fot_reg |-> low_reg == fot_cyc)
        else $error("Frame overhead length wrong.");
    fot_cause_a: assert property ($fell(frame_valid) |-> req_reg || !seq_rst_n || master_reg)
        else $error("Frame ended without a request.");
    row_width_a: assert property ($fell(line_valid) && seq_rst_n |-> words_reg == width_reg)
        else $error("Row word count differs from window width.");
    pin_dir_a: assert property ($stable(master_reg) [*2] |-> dev_int_oe == {3{master_reg}})
        else $error("Integration pin direction wrong for mode.");

    cover property ($rose(frame_valid) && fot_reg);
    cover property ($fell(line_valid) && seq_rst_n);
    cover property (req);
endmodule : sensor_link_checker

// ---- tb/image_sensor_sequencer_control_test.sv ----
`timescale 1ns/1ns
module image_sensor_sequencer_control_test;
    logic        clock;
    logic        nrst;
    logic [11:0] start_x;
    logic [11:0] start_y;
    logic [11:0] width;
    logic [1:0]  overhead_granularity;
    logic [11:0] win_rows;
    logic [11:0] int_rows;
    logic [9:0]  out_data;
    logic        out_valid;
    logic        out_ready;
    logic        busy;
    logic        pixel_reset;
    logic        integrating;
    logic        lower_reset;
    int          errors;
    int          n_checks;

    sensor_link_if link ();
    sensor_readout_dev sensor_readout_dev_i (.clock(clock), .nrst(nrst), .link(link),
        .pixel_reset(pixel_reset), .integrating(integrating), .lower_reset(lower_reset));
    sensor_camera_ctl sensor_camera_ctl_i (.clock(clock), .nrst(nrst), .link(link),
        .start_x(start_x), .start_y(start_y), .width(width), .overhead_granularity(overhead_granularity),
        .win_rows(win_rows), .int_rows(int_rows), .out_data(out_data),
        .out_valid(out_valid), .out_ready(out_ready), .busy(busy));
    sensor_link_checker sensor_link_checker_i (.clock(clock), .nrst(nrst),
        .seq_rst_n(link.seq_rst_n), .cfg_wr(link.cfg_wr), .cfg_addr(link.cfg_addr),
        .cfg_data(link.cfg_data), .dev_int_oe(link.dev_int_oe), .int_time(link.int_time),
        .line_valid(link.line_valid), .frame_valid(link.frame_valid),
        .pix_strobe(link.pix_strobe));

    task automatic check_word(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_flag(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask : check_flag

    task automatic complete_run;
        $display("Checks %0d, errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // A fresh power-on for every scenario, so the controller uploads the new settings.
    task automatic setup(input logic [11:0] sx, sy, w, input logic [1:0] g,
                         input logic [11:0] wr, ir);
        @(negedge clock);
        nrst     = 1'b0;
        start_x  = sx;
        start_y  = sy;
        width    = w;
        overhead_granularity     = g;
        win_rows = wr;
        int_rows = ir;
        repeat (2) @(negedge clock);
        nrst = 1'b1;
    endtask : setup

    // Two frames are expected; rows past the array or the window never reach the output.
    task automatic expect_stream(input int sx, sy, w, wr, stall);
        int rows;
        int t;
        rows = (sy + wr > 480) ? 480 - sy : wr;
        for (int f = 0; f < 2; f++) begin
            for (int r = 0; r < rows; r++) begin
                for (int c = 0; c < w; c++) begin
                    repeat (stall) @(negedge clock) out_ready = 1'b0;
                    @(negedge clock);
                    out_ready = 1'b1;
                    t = 0;
                    while (out_valid !== 1'b1 && t < 5000) begin
                        @(negedge clock);
                        t++;
                    end
                    check_flag(out_valid, 1'b1);
                    check_word(out_data, 10'((sx + c) ^ (sy + r)));
                end
            end
        end
        check_flag(busy, 1'b1);
    endtask : expect_stream

    task automatic t_window;
        setup(12'h005, 12'h00a, 12'h008, 2'h0, 12'h004, 12'h002);
        expect_stream(5, 10, 8, 4, 0);
    endtask : t_window

    task automatic t_beyond;
        setup(12'h003, 12'h1de, 12'h006, 2'h1, 12'h005, 12'h009);
        expect_stream(3, 478, 6, 5, 0);
    endtask : t_beyond

    task automatic t_stall;
        setup(12'h000, 12'h000, 12'h00c, 2'h2, 12'h003, 12'h001);
        expect_stream(0, 0, 12, 3, 9);
    endtask : t_stall

    task automatic t_pins;
        int t;
        setup(12'h3e8, 12'h014, 12'h004, 2'h3, 12'h002, 12'h003);
        // stream first, since the first row drains unseen while the pins are watched.
        expect_stream(1000, 20, 4, 2, 0);
        t = 0;
        while (link.int_time !== 3'h6 && t < 5000) begin
            @(negedge clock);
            t++;
        end
        repeat (2) @(negedge clock);
        check_flag(pixel_reset, 1'b1);
        while (link.int_time !== 3'h7 && t < 5000) begin
            @(negedge clock);
            t++;
        end
        repeat (3) @(negedge clock);
        check_flag(integrating, 1'b1);
        check_flag(lower_reset, 1'b0);
    endtask : t_pins

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        #600000;
        errors++;
        complete_run();
    end

    initial begin
        errors    = 0;
        n_checks  = 0;
        nrst      = 1'b0;
        start_x   = 12'h000;
        start_y   = 12'h000;
        width     = 12'h008;
        overhead_granularity      = 2'h0;
        win_rows  = 12'h002;
        int_rows  = 12'h001;
        out_ready = 1'b1;
        repeat (12) @(negedge clock);
        t_window();
        t_beyond();
        t_stall();
        t_pins();
        complete_run();
    end
endmodule : image_sensor_sequencer_control_test
